/* File: common/pic_pkg.sv */
package pic_pkg;

   // ****************************************************************
   // fixed point and ranges
   // ****************************************************************
   localparam int GAIN_FRAC     = 100;        // gains carry two decimals
   localparam int OUT_MIN       = 0;
   localparam int OUT_MAX       = 1000;
   localparam int VAL_MIN       = -10000;
   localparam int VAL_MAX       = 20000;
   localparam int LOOP_GAIN_MAX = 9999;       // 99.99
   localparam int SCALE_MAX     = 1000;       // 10.00
   localparam int ITIME_SEC_MIN = 1;          // 00:01
   localparam int ITIME_SEC_OFF = 99 * 60 + 59; // 99:59 switches I off
   localparam int INT_FRAC      = 1024;       // integral sum fraction

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_MHZ       = 250;
   localparam int SAMPLE_MS     = 500;
   localparam int SAMPLE_CYC    = SAMPLE_MS * 1000 * CLK_MHZ;
   localparam int SAMPLE_MS_PER_SEC = 1000;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      PIC_IDLE  = 2'b00,
      PIC_SCALE = 2'b01,
      PIC_ERROR = 2'b11,
      PIC_CALC  = 2'b10
   } pic_state_t;

   typedef struct packed {
      logic signed [15:0] lowLimit;
      logic signed [15:0] highLimit;
      logic        [15:0] scaleGain;   // hundredths, 0..1000
      logic signed [15:0] scaleOffset;
   } pic_scale_t;

   typedef struct packed {
      logic [13:0] loopGain;           // hundredths, 0..9999
      logic [12:0] integralTime;       // seconds, 1..5999
      logic        directionNeg;       // 1 selects minus action
      logic [9:0]  manualOutputValue;  // 0..1000
   } pic_tune_t;

endpackage : pic_pkg

/* File: hdl/pic_sample_timer.sv */
`timescale 1ns/100ps
// ******************************************************************
// sample tick generator
// ******************************************************************
module pic_sample_timer #(
   parameter int PERIOD = pic_pkg::SAMPLE_CYC
) (
   input  wire logic clk,
   input  wire logic rst,
   output logic      tick
);
   if (PERIOD < 2) begin : g_bad_period
      $error("sample period too short");
   end

   logic [31:0] count_q;

   // free running divider, tick on wrap
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_q <= 32'h0;
         tick    <= 1'b0;
      end else if (count_q == 32'(PERIOD - 1)) begin
         count_q <= 32'h0;
         tick    <= 1'b1;
      end else begin
         count_q <= count_q + 32'h1;
         tick    <= 1'b0;
      end
   end

   chk_tick_period: assert property (
      @(posedge clk) disable iff (rst)
      tick |-> count_q == 32'h0)
      else $error("tick not aligned to divider wrap");
endmodule : pic_sample_timer

/* File: hdl/pic_controller.sv */
`timescale 1ns/100ps
module pic_controller #(
   parameter int SAMPLE_PERIOD = pic_pkg::SAMPLE_CYC
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic signed [15:0] processInput,
   input  wire logic signed [15:0] setpointValue,
   input  wire pic_pkg::pic_scale_t scaleCfg,
   input  wire pic_pkg::pic_tune_t  tuneCfg,
   input  wire logic               autoMode,
   input  wire logic               outputReset,
   output logic             [9:0]  controllerOutput,
   output logic signed      [15:0] processValue,
   output logic                    sampleDone
);
   // refuse a period too short for the four state pass
   if (SAMPLE_PERIOD < 8) begin : g_bad_period
      $error("sample period too short");
   end
   // the output register holds ten bits
   if (pic_pkg::OUT_MAX > 1023) begin : g_bad_range
      $error("output range exceeds ten bits");
   end

   // ****************************************************************
   // sample tick
   // ****************************************************************
   logic tick;

   pic_sample_timer #(.PERIOD(SAMPLE_PERIOD)) u_timer (
      .clk  (clk),
      .rst  (rst),
      .tick (tick)
   );

   // ****************************************************************
   // sequencer
   // ****************************************************************
   pic_pkg::pic_state_t state_q;
   logic                autoMode_q;

   // one pass per tick: scale, error, calculate
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= pic_pkg::PIC_IDLE;
      end else begin
         case (state_q)
            pic_pkg::PIC_IDLE:  if (tick) state_q <= pic_pkg::PIC_SCALE;
            pic_pkg::PIC_SCALE: state_q <= pic_pkg::PIC_ERROR;
            pic_pkg::PIC_ERROR: state_q <= pic_pkg::PIC_CALC;
            default:            state_q <= pic_pkg::PIC_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // process value scaling and clamping
   // ****************************************************************
   logic signed [47:0] scaledRaw;
   logic signed [47:0] procScaled;
   logic signed [15:0] procValue_d;

   // input times gain in hundredths, rounded, plus offset
   always_comb begin
      scaledRaw  = 48'(processInput)
                   * 48'(signed'({1'b0, scaleCfg.scaleGain}));
      procScaled = (scaledRaw + 48'(pic_pkg::GAIN_FRAC / 2))
                   / 48'(pic_pkg::GAIN_FRAC)
                   + 48'(scaleCfg.scaleOffset);
      if (procScaled > 48'(scaleCfg.highLimit))
         procValue_d = scaleCfg.highLimit;
      else if (procScaled < 48'(scaleCfg.lowLimit))
         procValue_d = scaleCfg.lowLimit;
      else
         procValue_d = procScaled[15:0];
   end

   // latch the clamped value in the scale cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         processValue <= 16'sh0;
      end else if (state_q == pic_pkg::PIC_SCALE) begin
         processValue <= procValue_d;
      end
   end

   // ****************************************************************
   // loop error with action direction
   // ****************************************************************
   logic signed [17:0] error_q;

   // error is setpoint minus process value, negated for minus direction
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         error_q <= 18'sh0;
      end else if (state_q == pic_pkg::PIC_ERROR) begin
         if (tuneCfg.directionNeg)
            error_q <= 18'(processValue) - 18'(setpointValue);
         else
            error_q <= 18'(setpointValue) - 18'(processValue);
      end
   end

   // ****************************************************************
   // gains
   // ****************************************************************
   logic [13:0] propGain;
   logic [13:0] intGain;

   // shared gain, zero gain switches P off and I to unity
   always_comb begin
      if (tuneCfg.loopGain == 14'h0) begin
         propGain = 14'h0;
         intGain  = 14'(pic_pkg::GAIN_FRAC);
      end else begin
         propGain = tuneCfg.loopGain;
         intGain  = tuneCfg.loopGain;
      end
   end

   // ****************************************************************
   // integral and output calculation
   // ****************************************************************
   // integral sum is output units scaled by INT_FRAC
   logic signed [47:0] intSum_q;
   logic signed [47:0] intStep;
   logic signed [47:0] intNew;
   logic signed [47:0] propTerm;
   logic signed [47:0] total;
   logic               intOff;
   logic [12:0]        itimeSec;
   logic signed [63:0] intNum;
   logic signed [63:0] intDen;
   logic [9:0]         calcOut;
   logic               satHigh;
   logic               satLow;

   always_comb begin
      itimeSec = (tuneCfg.integralTime < 13'(pic_pkg::ITIME_SEC_MIN))
                 ? 13'(pic_pkg::ITIME_SEC_MIN) : tuneCfg.integralTime;
      intOff = (itimeSec >= 13'(pic_pkg::ITIME_SEC_OFF));
      // gain times sample period over integral time times error; the
      // full-range product overflows 48 bits, so divide in 64 bits
      intNum = 64'(error_q) * 64'(signed'({1'b0, intGain}))
               * 64'(pic_pkg::SAMPLE_MS) * 64'(pic_pkg::INT_FRAC);
      intDen = 64'(signed'({1'b0, itimeSec})) * 64'(pic_pkg::GAIN_FRAC)
               * 64'(pic_pkg::SAMPLE_MS_PER_SEC);
      intStep = 48'(intNum / intDen);
      if (intOff)
         intStep = 48'sh0;
      propTerm = 48'(error_q) * 48'(signed'({1'b0, propGain}))
                 * 48'(pic_pkg::INT_FRAC) / 48'(pic_pkg::GAIN_FRAC);
      intNew = intSum_q + intStep;
      total  = propTerm + intNew;
      satHigh = total >= 48'(pic_pkg::OUT_MAX * pic_pkg::INT_FRAC);
      satLow  = total <= 48'(pic_pkg::OUT_MIN);
      // anti windup: hold sum when pushing further into a limit
      if ((satHigh && intStep > 48'sh0) || (satLow && intStep < 48'sh0))
         intNew = intSum_q;
      if (satHigh)
         calcOut = 10'(pic_pkg::OUT_MAX);
      else if (satLow)
         calcOut = 10'(pic_pkg::OUT_MIN);
      else
         calcOut = 10'((total + 48'(pic_pkg::INT_FRAC / 2))
                       / 48'(pic_pkg::INT_FRAC));
   end

   // mode tracking for the manual to automatic edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         autoMode_q <= 1'b0;
      end else begin
         autoMode_q <= autoMode && !outputReset;
      end
   end

   // integral sum: preset on entering auto, step per sample
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         intSum_q <= 48'sh0;
      end else if (outputReset) begin
         intSum_q <= 48'sh0;
      end else if (!autoMode || !autoMode_q) begin
         intSum_q <= 48'(tuneCfg.manualOutputValue)
                     * 48'(pic_pkg::INT_FRAC);
      end else if (state_q == pic_pkg::PIC_CALC) begin
         intSum_q <= intNew;
      end
   end

   // output selection: reset over manual over automatic
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         controllerOutput <= 10'h0;
      end else if (outputReset) begin
         controllerOutput <= 10'h0;
      end else if (!autoMode) begin
         controllerOutput <= tuneCfg.manualOutputValue;
      end else if (autoMode_q && state_q == pic_pkg::PIC_CALC) begin
         controllerOutput <= calcOut;
      end
   end

   // one cycle pulse when the calculation pass ends
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sampleDone <= 1'b0;
      end else begin
         sampleDone <= (state_q == pic_pkg::PIC_CALC);
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   chk_out_range: assert property (
      @(posedge clk) disable iff (rst)
      controllerOutput <= 10'(pic_pkg::OUT_MAX))
      else $error("output above range");
   chk_reset_zero: assert property (
      @(posedge clk) disable iff (rst)
      outputReset |=> controllerOutput == 10'h0)
      else $error("output reset not honoured");
   chk_manual_out: assert property (
      @(posedge clk) disable iff (rst)
      (!autoMode && !outputReset) |=>
      controllerOutput == $past(tuneCfg.manualOutputValue))
      else $error("manual value not driven");
   chk_proc_clamp: assert property (
      @(posedge clk) disable iff (rst)
      $past(state_q) == pic_pkg::PIC_SCALE && $past(scaleCfg.lowLimit)
      <= $past(scaleCfg.highLimit) |->
      processValue >= $past(scaleCfg.lowLimit) &&
      processValue <= $past(scaleCfg.highLimit))
      else $error("process value outside limits");
   chk_sample_seq: assert property (
      @(posedge clk) disable iff (rst)
      tick && state_q == pic_pkg::PIC_IDLE |=> ##2 sampleDone == 1'b0
      ##1 sampleDone)
      else $error("sample pass not three cycles");
   chk_gain_zero: assert property (
      @(posedge clk) disable iff (rst)
      tuneCfg.loopGain == 14'h0 |->
      propGain == 14'h0 && intGain == 14'(pic_pkg::GAIN_FRAC))
      else $error("zero gain special case wrong");
   chk_gain_shared: assert property (
      @(posedge clk) disable iff (rst)
      tuneCfg.loopGain != 14'h0 |->
      propGain == tuneCfg.loopGain && intGain == propGain)
      else $error("gain not shared");
   chk_int_off: assert property (
      @(posedge clk) disable iff (rst)
      tuneCfg.integralTime >= 13'(pic_pkg::ITIME_SEC_OFF) |->
      intStep == 48'sh0)
      else $error("integral not switched off");
   chk_auto_preset: assert property (
      @(posedge clk) disable iff (rst)
      $rose(autoMode) && !outputReset |=>
      intSum_q == 48'($past(tuneCfg.manualOutputValue))
      * 48'(pic_pkg::INT_FRAC))
      else $error("integral not preset on auto entry");
   // the stored sum must not move on an automatic pass while the integral is off
   chk_int_frozen: assert property (
      @(posedge clk) disable iff (rst)
      state_q == pic_pkg::PIC_CALC && autoMode && autoMode_q &&
      !outputReset && tuneCfg.integralTime >= 13'(pic_pkg::ITIME_SEC_OFF)
      |=> intSum_q == $past(intSum_q))
      else $error("integral sum moved with integral off");
   // zero gain, one second: half the error per sample in sum units
   chk_unity_igain: assert property (
      @(posedge clk) disable iff (rst)
      tuneCfg.loopGain == 14'h0 && tuneCfg.integralTime == 13'h1 |->
      intStep == 48'(error_q) * 48'(pic_pkg::SAMPLE_MS * pic_pkg::INT_FRAC
                                     / pic_pkg::SAMPLE_MS_PER_SEC))
      else $error("unity integral gain not applied");
   chk_done_pulse: assert property (
      @(posedge clk) disable iff (rst)
      sampleDone |=> !sampleDone)
      else $error("pass done longer than one cycle");
   // automatic output only moves at the end of a pass
   chk_auto_hold: assert property (
      @(posedge clk) disable iff (rst)
      autoMode && !outputReset && state_q != pic_pkg::PIC_CALC |=>
      $stable(controllerOutput))
      else $error("automatic output moved between passes");

   cov_auto_sample: cover property (@(posedge clk) disable iff (rst)
      autoMode_q && sampleDone);
   cov_sat_high: cover property (@(posedge clk) disable iff (rst)
      controllerOutput == 10'(pic_pkg::OUT_MAX));
   cov_neg_dir: cover property (@(posedge clk) disable iff (rst)
      tuneCfg.directionNeg && sampleDone);
   cov_reset_in: cover property (@(posedge clk) disable iff (rst)
      $fell(outputReset) && autoMode);
   cov_int_off: cover property (@(posedge clk) disable iff (rst)
      intOff && autoMode_q && sampleDone);
endmodule : pic_controller

/* File: sim/pic_plant_model.sv */
`timescale 1ns/100ps
// ********************
// analog source and actuator stand-in
// ********************
module pic_plant_model (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic signed [15:0] level,
   input  wire logic        [9:0]  controllerOutput,
   output logic signed      [15:0] processInput,
   output logic             [9:0]  actuatorLevel
);
   // source settles one cycle after a level change
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         processInput  <= 16'h0000;
         actuatorLevel <= 10'h000;
      end else begin
         processInput  <= level;
         actuatorLevel <= controllerOutput; // actuator follows output
      end
   end
endmodule : pic_plant_model

/* File: sim/tb.sv */
`timescale 1ns/100ps
module tb;
   localparam int PERIOD = 20;
   logic                clk;
   logic                rst;
   logic                autoMode;
   logic                outputReset;
   logic signed [15:0]  rawLevel;
   logic signed [15:0]  setpointValue;
   logic signed [15:0]  processInput;
   logic signed [15:0]  processValue;
   pic_pkg::pic_scale_t scaleCfg;
   pic_pkg::pic_tune_t  tuneCfg;
   logic        [9:0]  controllerOutput;
   logic        [9:0]  actuatorLevel;
   logic                sampleDone;
   int                  nErrors;
   int                  nCompared;

   // ********************
   // design and partner
   // ********************
   pic_controller #(.SAMPLE_PERIOD(PERIOD)) pic_controller_inst (
      .clk(clk), .rst(rst), .processInput(processInput),
      .setpointValue(setpointValue), .scaleCfg(scaleCfg),
      .tuneCfg(tuneCfg), .autoMode(autoMode), .outputReset(outputReset),
      .controllerOutput(controllerOutput), .processValue(processValue),
      .sampleDone(sampleDone));
   pic_plant_model pic_plant_model_inst (
      .clk(clk), .rst(rst), .level(rawLevel),
      .controllerOutput(controllerOutput), .processInput(processInput),
      .actuatorLevel(actuatorLevel));

   // clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ********************
   // shared tasks
   // ********************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         nErrors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // wait for the next finished pass, bounded
   task automatic waitPass;
      for (int i = 0; i < 4 * PERIOD; i++) begin
         @(posedge clk);
         #1;
         if (sampleDone === 1'b1) break;
      end
      check(sampleDone, 1'b1);
   endtask : waitPass

   task automatic expectOut(input logic [9:0] exp);
      waitPass;
      check(controllerOutput, exp);
   endtask : expectOut

   task automatic setScale(input logic signed [15:0] g, off, lo, hi);
      @(posedge clk);
      scaleCfg.scaleGain   <= g;
      scaleCfg.scaleOffset <= off;
      scaleCfg.lowLimit    <= lo;
      scaleCfg.highLimit   <= hi;
   endtask : setScale

   task automatic setLoop(input logic [13:0] g, input logic [12:0] itime,
                          input logic neg, input logic signed [15:0] setp);
      @(posedge clk);
      tuneCfg.loopGain     <= g;
      tuneCfg.integralTime <= itime;
      tuneCfg.directionNeg <= neg;
      setpointValue        <= setp;
   endtask : setLoop

   task automatic setAuto(input logic a);
      @(posedge clk);
      autoMode <= a;
   endtask : setAuto

   task automatic settle(input logic [9:0] exp);
      repeat (2) @(posedge clk);
      #1;
      check(controllerOutput, exp);
      check(actuatorLevel, exp);
   endtask : settle

   // ********************
   // scenarios
   // ********************
   task automatic scnManualScale;
      logic signed [15:0] t [5][6] = '{
         '{16'h01f4, 16'h000f, -16'sh0032, -16'sh2710, 16'h4e20, 16'h0019},
         '{16'h03e8, 16'h03e8, 16'h0000, -16'sh2710, 16'h4e20, 16'h2710},
         '{16'h4e20, 16'h0064, 16'h0000, -16'sh2710, 16'h1388, 16'h1388},
         '{-16'sh07d0, 16'h0064, 16'h0000, -16'sh03e8, 16'h4e20, -16'sh03e8},
         '{16'h0000, 16'h0000, 16'h4e20, -16'sh2710, 16'h4e20, 16'h4e20}};
      settle(10'h1f4);
      for (int i = 0; i < 5; i++) begin
         setScale(t[i][1], t[i][2], t[i][3], t[i][4]);
         rawLevel <= t[i][0];
         waitPass;
         check(processValue, t[i][5]);
         check(controllerOutput, 10'h1f4);
      end
      setScale(16'h0064, 16'h0000, -16'sh2710, 16'h4e20);
      rawLevel <= 16'h0000;
      waitPass;
   endtask : scnManualScale

   task automatic scnPeriod;
      int n;
      waitPass;
      @(posedge clk);
      #1;
      check(sampleDone, 1'b0);
      n = 1;
      while (sampleDone !== 1'b1 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      check(n, PERIOD);
   endtask : scnPeriod

   task automatic scnIntegral;
      setLoop(14'h0000, 13'h0001, 1'b0, 16'h0064);
      setAuto(1'b1);
      expectOut(10'h226);
      expectOut(10'h258);
      setLoop(14'h0000, 13'h0001, 1'b0, -16'sh0064);
      expectOut(10'h226);
      setAuto(1'b0);
      settle(10'h1f4);
   endtask : scnIntegral

   task automatic scnPiWindup;
      setLoop(14'h00c8, 13'h0001, 1'b0, 16'h0078);
      setAuto(1'b1);
      expectOut(10'h35c);
      expectOut(10'h3d4);
      expectOut(10'h3e8);
      expectOut(10'h3e8);
      setLoop(14'h00c8, 13'h0001, 1'b0, 16'h0000);
      expectOut(10'h2e4);
      setLoop(14'h00c8, 13'h0001, 1'b0, -16'sh2710);
      expectOut(10'h000);
      setAuto(1'b0);
   endtask : scnPiWindup

   task automatic scnDirTime;
      setLoop(14'h0000, 13'h0001, 1'b1, 16'h0064);
      setAuto(1'b1);
      expectOut(10'h1c2);
      expectOut(10'h190);
      setAuto(1'b0);
      setLoop(14'h0064, 13'h176f, 1'b0, 16'h0064);
      setAuto(1'b1);
      expectOut(10'h258);
      expectOut(10'h258);
      setAuto(1'b0);
      setLoop(14'h0000, 13'h0002, 1'b0, 16'h0064);
      setAuto(1'b1);
      expectOut(10'h20d);
      setAuto(1'b0);
   endtask : scnDirTime

   task automatic scnOutReset;
      setLoop(14'h0000, 13'h0001, 1'b0, 16'h0064);
      setAuto(1'b1);
      expectOut(10'h226);
      @(posedge clk);
      outputReset <= 1'b1;
      settle(10'h000);
      expectOut(10'h000);
      @(posedge clk);
      outputReset <= 1'b0;
      expectOut(10'h226);
      setAuto(1'b0);
      @(posedge clk);
      outputReset <= 1'b1;
      settle(10'h000);
      @(posedge clk);
      outputReset <= 1'b0;
      settle(10'h1f4);
   endtask : scnOutReset

   task automatic wrapUp;
      $display("compared %0d, errors %0d", nCompared, nErrors);
      if (nErrors == 0 && nCompared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrapUp

   // main sequence
   initial begin
      nErrors = 0;
      nCompared = 0;
      rst = 1'b1;
      autoMode = 1'b0;
      outputReset = 1'b0;
      rawLevel = 16'h0000;
      setpointValue = 16'h0000;
      scaleCfg = '{-16'sh2710, 16'h4e20, 16'h0064, 16'h0000};
      tuneCfg = '{14'h0000, 13'h0001, 1'b0, 10'h1f4};
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      check(controllerOutput, 10'h000);
      check(sampleDone, 1'b0);
      scnManualScale;
      scnPeriod;
      scnIntegral;
      scnPiWindup;
      scnDirTime;
      scnOutReset;
      wrapUp;
   end

   // watchdog
   initial begin
      #(5000 * 4);
      nErrors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
      wrapUp;
   end
endmodule : tb
